// [core/smr_defines.svh]
`ifndef SMR_DEFINES_SVH
`define SMR_DEFINES_SVH

// Base of the private region after hardware reset
`define SMR_BASE_RESET     32'h0003_0000
// Handler entry point, relative to the region base
`define SMR_ENTRY_OFS      32'h0000_8000
// State save area bounds, relative to the region base
`define SMR_SAVE_LO        32'h0000_fe00
`define SMR_SAVE_HI        32'h0000_ffff
// Save map field offsets, relative to the entry point
`define SMR_OFS_BASE       32'h0000_7ef8
`define SMR_OFS_REV        32'h0000_7efc
`define SMR_OFS_RESTART    32'h0000_7f00
// Restart field codes
`define SMR_RESTART_YES    8'hff
`define SMR_RESTART_NO     8'h00
// Revision identifier layout
`define SMR_REV_IORST_BIT  16
`define SMR_REV_RELOC_BIT  17
`define SMR_REV_VERSION    16'h0001
// Legacy 32-KByte alignment mask
`define SMR_ALIGN_MASK     32'h0000_7fff
// Byte enables for save map writes
`define SMR_BE_WORD        4'hf
`define SMR_BE_HALF        4'h3

`endif

// [core/smr_pkg.sv]
package smr_pkg;

    // Entry, handler, resume and failure phases
    typedef enum logic [2:0] {
        SMR_IDLE,
        SMR_WR_REV,
        SMR_WR_RST,
        SMR_HANDLER,
        SMR_RD_BASE,
        SMR_RD_RST,
        SMR_SHUTDOWN
    } smr_state_t;

endpackage

// [core/smr_pin_sync.sv]
`timescale 1ns/1ns

module smr_pin_sync (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic ce,
    // Asynchronous active-low request pin
    input  wire logic pin_n,
    // One-cycle pulse on each assertion of the pin
    output logic      fall
);

    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    logic last_q;
    logic last_d;
    logic fall_q;
    logic fall_d;

    // Two stages first; only the second stage feeds the edge detector
    always_comb begin
        meta_d = pin_n;
        sync_d = meta_q;
        last_d = sync_q;
        fall_d = last_q & ~sync_q;
    end

    // Idle level of the pin is high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
            fall_q <= 1'b0;
        end else if (ce) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
            fall_q <= fall_d;
        end
    end

    assign fall = fall_q;

endmodule

// [core/smr_core.sv]
`timescale 1ns/1ns
`include "smr_defines.svh"

module smr_core
    import smr_pkg::*;
(
    // Clock, reset, clock enable
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    // Request sources
    input  wire logic        management_request_pin_n,
    input  wire logic        lic_request,
    // Processor core events
    input  wire logic        soft_init,
    input  wire logic        resume_from_management,
    input  wire logic        legacy_align,
    input  wire logic        io_trap,
    input  wire logic [31:0] io_ip,
    input  wire logic [31:0] next_ip,
    // Save map memory port
    output logic             mem_req,
    output logic             mem_we,
    output logic [3:0]       mem_be,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    // Status and control flow outputs
    output logic             management_active,
    output logic             fetch_valid,
    output logic [31:0]      fetch_addr,
    output logic             resume_valid,
    output logic [31:0]      instruction_pointer,
    output logic             shutdown,
    output logic [31:0]      mgmt_region_base
);

    // Save map address of a field for a given region base
    function automatic logic [31:0] map_addr(input logic [31:0] base,
                                             input logic [31:0] ofs);
        map_addr = 32'(base + `SMR_ENTRY_OFS + ofs);
    endfunction

    // Revision word with both capability flags set
    function automatic logic [31:0] rev_word();
        logic [31:0] w;
        w = {16'h0000, `SMR_REV_VERSION};
        w[`SMR_REV_IORST_BIT] = 1'b1;
        w[`SMR_REV_RELOC_BIT] = 1'b1;
        rev_word = w;
    endfunction

    smr_state_t  state_q, state_d;
    logic [31:0] base_q, base_d;
    logic [31:0] rd_base_q, rd_base_d;
    logic [31:0] io_ip_q, io_ip_d;
    logic [31:0] next_ip_q, next_ip_d;
    logic        io_valid_q, io_valid_d;
    logic        pend_q, pend_d;
    logic        req_q, req_d;
    logic        we_q, we_d;
    logic [3:0]  be_q, be_d;
    logic [31:0] addr_q, addr_d;
    logic [31:0] wdata_q, wdata_d;
    logic        active_q, active_d;
    logic        fvalid_q, fvalid_d;
    logic [31:0] faddr_q, faddr_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rip_q, rip_d;
    logic        shut_q, shut_d;
    logic        pin_evt;
    logic        req_evt;
    logic        misaligned;
    logic [31:0] target_ip;

    // Pin passes three flops before use
    smr_pin_sync u_pin_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .pin_n   (management_request_pin_n),
        .fall    (pin_evt)
    );

    // Either source raises a request
    assign req_evt = pin_evt | lic_request;

    // Alignment only matters for legacy parts
    assign misaligned = legacy_align && ((rd_base_q & `SMR_ALIGN_MASK) != 0);

    // Only FFH restarts; any other value continues
    assign target_ip = (mem_rdata[7:0] == `SMR_RESTART_YES) ? io_ip_q
                                                           : next_ip_q;

    // Next-state logic for entry, handler and resume sequencing
    always_comb begin
        state_d    = state_q;
        base_d     = base_q;
        rd_base_d  = rd_base_q;
        io_ip_d    = io_ip_q;
        next_ip_d  = next_ip_q;
        io_valid_d = io_valid_q;
        pend_d     = pend_q | req_evt; // New request beats any clear
        req_d      = req_q;
        we_d       = we_q;
        be_d       = be_q;
        addr_d     = addr_q;
        wdata_d    = wdata_q;
        active_d   = active_q;
        fvalid_d   = 1'b0;
        faddr_d    = faddr_q;
        rvalid_d   = 1'b0;
        rip_d      = rip_q;
        shut_d     = shut_q;
        unique case (state_q)
            SMR_IDLE: begin
                if (pend_q) begin
                    pend_d     = req_evt;
                    io_valid_d = io_trap;
                    io_ip_d    = io_ip;
                    next_ip_d  = next_ip;
                    active_d   = 1'b1;
                    req_d      = 1'b1;
                    we_d       = 1'b1;
                    be_d       = `SMR_BE_WORD;
                    addr_d     = map_addr(base_q, `SMR_OFS_REV);
                    wdata_d    = rev_word();
                    state_d    = SMR_WR_REV;
                end
            end
            SMR_WR_REV: begin
                if (mem_ack) begin
                    be_d    = `SMR_BE_HALF;
                    addr_d  = map_addr(base_q, `SMR_OFS_RESTART);
                    wdata_d = {24'h000000, `SMR_RESTART_NO};
                    state_d = SMR_WR_RST;
                end
            end
            SMR_WR_RST: begin
                if (mem_ack) begin
                    req_d    = 1'b0;
                    we_d     = 1'b0;
                    fvalid_d = 1'b1;
                    faddr_d  = 32'(base_q + `SMR_ENTRY_OFS);
                    state_d  = SMR_HANDLER;
                end
            end
            SMR_HANDLER: begin
                // Base is not touched while the handler runs
                if (resume_from_management) begin
                    req_d   = 1'b1;
                    we_d    = 1'b0;
                    addr_d  = map_addr(base_q, `SMR_OFS_BASE);
                    state_d = SMR_RD_BASE;
                end
            end
            SMR_RD_BASE: begin
                if (mem_ack) begin
                    rd_base_d = mem_rdata;
                    addr_d    = map_addr(base_q, `SMR_OFS_RESTART);
                    state_d   = SMR_RD_RST;
                end
            end
            SMR_RD_RST: begin
                if (mem_ack) begin
                    req_d = 1'b0;
                    if (misaligned) begin
                        shut_d  = 1'b1;
                        state_d = SMR_SHUTDOWN;
                    end else begin
                        base_d = rd_base_q;
                        if (pend_q) begin
                            // Nested entry; restart target saved as return
                            pend_d     = req_evt;
                            io_valid_d = 1'b0;
                            next_ip_d  = target_ip;
                            req_d      = 1'b1;
                            we_d       = 1'b1;
                            be_d       = `SMR_BE_WORD;
                            addr_d     = map_addr(rd_base_q, `SMR_OFS_REV);
                            wdata_d    = rev_word();
                            state_d    = SMR_WR_REV;
                        end else begin
                            rvalid_d = 1'b1;
                            rip_d    = target_ip;
                            active_d = 1'b0;
                            state_d  = SMR_IDLE;
                        end
                    end
                end
            end
            SMR_SHUTDOWN: begin
                // Only hardware reset leaves shutdown
                state_d = SMR_SHUTDOWN;
            end
            default: begin
                state_d = SMR_IDLE;
            end
        endcase
    end

    // Soft init is not an input of this register file
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q    <= SMR_IDLE;
            base_q     <= `SMR_BASE_RESET;
            rd_base_q  <= `SMR_BASE_RESET;
            io_ip_q    <= 32'h0000_0000;
            next_ip_q  <= 32'h0000_0000;
            io_valid_q <= 1'b0;
            pend_q     <= 1'b0;
            req_q      <= 1'b0;
            we_q       <= 1'b0;
            be_q       <= 4'h0;
            addr_q     <= 32'h0000_0000;
            wdata_q    <= 32'h0000_0000;
            active_q   <= 1'b0;
            fvalid_q   <= 1'b0;
            faddr_q    <= 32'h0000_0000;
            rvalid_q   <= 1'b0;
            rip_q      <= 32'h0000_0000;
            shut_q     <= 1'b0;
        end else if (ce) begin
            state_q    <= state_d;
            base_q     <= base_d;
            rd_base_q  <= rd_base_d;
            io_ip_q    <= io_ip_d;
            next_ip_q  <= next_ip_d;
            io_valid_q <= io_valid_d;
            pend_q     <= pend_d;
            req_q      <= req_d;
            we_q       <= we_d;
            be_q       <= be_d;
            addr_q     <= addr_d;
            wdata_q    <= wdata_d;
            active_q   <= active_d;
            fvalid_q   <= fvalid_d;
            faddr_q    <= faddr_d;
            rvalid_q   <= rvalid_d;
            rip_q      <= rip_d;
            shut_q     <= shut_d;
        end
    end

    // Outputs straight from flops
    assign mem_req             = req_q;
    assign mem_we              = we_q;
    assign mem_be              = be_q;
    assign mem_addr            = addr_q;
    assign mem_wdata           = wdata_q;
    assign management_active   = active_q;
    assign fetch_valid         = fvalid_q;
    assign fetch_addr          = faddr_q;
    assign resume_valid        = rvalid_q;
    assign instruction_pointer = rip_q;
    assign shutdown            = shut_q;
    assign mgmt_region_base    = base_q;

    // Checks next to the sequencing logic
    a_base_only_resume: assert property (
        @(posedge clk_sys) disable iff (rst)
        (state_q != SMR_RD_RST) |=> $stable(base_q)
    ) else $error("region base changed outside resume");

    a_base_reload_val: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && state_q == SMR_RD_RST && mem_ack && !misaligned)
        |=> (base_q == $past(rd_base_q))
    ) else $error("base not reloaded from save field");

    a_fetch_entry_addr: assert property (
        @(posedge clk_sys) disable iff (rst)
        fvalid_q |-> (faddr_q == 32'(base_q + `SMR_ENTRY_OFS))
    ) else $error("handler fetch address wrong");

    a_save_in_range: assert property (
        @(posedge clk_sys) disable iff (rst)
        req_q |-> (addr_q >= 32'(base_q + `SMR_SAVE_LO)
                   && addr_q <= 32'(base_q + `SMR_SAVE_HI))
    ) else $error("save map access outside save area");

    a_restart_cleared: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && state_q == SMR_WR_REV && mem_ack)
        |=> (wdata_q[7:0] == `SMR_RESTART_NO && be_q == `SMR_BE_HALF
             && addr_q == map_addr(base_q, `SMR_OFS_RESTART))
    ) else $error("restart field not cleared on entry");

    a_rev_caps_set: assert property (
        @(posedge clk_sys) disable iff (rst)
        (req_q && state_q == SMR_WR_REV)
        |-> (wdata_q[`SMR_REV_IORST_BIT] && wdata_q[`SMR_REV_RELOC_BIT])
    ) else $error("capability flags missing");

    a_align_shutdown: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && state_q == SMR_RD_RST && mem_ack && misaligned)
        |=> shut_q ##1 shut_q
    ) else $error("misaligned base did not shut down");

    a_restart_target: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && state_q == SMR_RD_RST && mem_ack && !misaligned && !pend_q
         && mem_rdata[7:0] == `SMR_RESTART_YES)
        |=> (rvalid_q && rip_q == $past(io_ip_q))
    ) else $error("restart did not return to trapped instruction");

    a_continue_target: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && state_q == SMR_RD_RST && mem_ack && !misaligned && !pend_q
         && mem_rdata[7:0] != `SMR_RESTART_YES)
        |=> (rvalid_q && rip_q == $past(next_ip_q))
    ) else $error("non-restart value did not continue");

    a_nested_first: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && state_q == SMR_RD_RST && mem_ack && !misaligned && pend_q)
        |=> (state_q == SMR_WR_REV && !rvalid_q && active_q)
    ) else $error("nested request not serviced first");

    a_soft_init_keep: assert property (
        @(posedge clk_sys) disable iff (rst)
        (soft_init && state_q != SMR_RD_RST) |=> $stable(base_q)
    ) else $error("soft init changed region base");

    a_trap_sampled: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ce && state_q == SMR_IDLE && pend_q)
        |=> (io_valid_q == $past(io_trap) && io_ip_q == $past(io_ip)
             && next_ip_q == $past(next_ip))
    ) else $error("entry state not captured");

endmodule

// [bench/smr_mem_model.sv]
`timescale 1ns/1ns

module smr_mem_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Save map port
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [3:0]  mem_be,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata,
    // Wait cycles before each ack
    input  wire logic [3:0]  delay
);
    // Sparse save map; handler software edits it from the bench
    logic [31:0] mem [logic [31:0]];
    logic [31:0] word;
    logic [3:0]  cnt_q;

    // Ack after the programmed wait; read data is garbage outside ack
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_ack <= 1'b0;
            cnt_q <= 4'h0;
            mem_rdata <= 32'h0;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            cnt_q <= 4'h0;
            mem_rdata <= ~mem_rdata;
        end else if (mem_req && cnt_q == delay) begin
            mem_ack <= 1'b1;
            word = mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
            if (mem_we) begin
                for (int i = 0; i < 4; i++)
                    if (mem_be[i]) word[i*8 +: 8] = mem_wdata[i*8 +: 8];
                mem[mem_addr] = word;
            end
            mem_rdata <= word;
        end else begin
            if (mem_req) cnt_q <= cnt_q + 4'h1;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// [bench/smr_base_relocate_io_restart_tb.sv]
`timescale 1ns/1ns
`include "smr_defines.svh"

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    mismatches++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end

module smr_base_relocate_io_restart_tb;
    import smr_pkg::*;

    // Distinct aligned bases, one per stage
    localparam logic [31:0] B1 = 32'h0004_0000;
    localparam logic [31:0] B2 = 32'h0005_0000;
    localparam logic [31:0] B3 = 32'h0006_0000;
    localparam logic [31:0] B4 = 32'h0007_0000;
    localparam logic [31:0] B5 = 32'h0008_0000;
    localparam logic [31:0] O_BASE = `SMR_ENTRY_OFS + `SMR_OFS_BASE;
    localparam logic [31:0] O_REV = `SMR_ENTRY_OFS + `SMR_OFS_REV;
    localparam logic [31:0] O_RST = `SMR_ENTRY_OFS + `SMR_OFS_RESTART;

    logic        clk_sys = 1'b0, rst = 1'b1, ce = 1'b1;
    logic        pin_n = 1'b1, lic_request = 1'b0, soft_init = 1'b0;
    logic        resume = 1'b0, legacy_align = 1'b0, io_trap = 1'b0;
    logic [31:0] io_ip = 32'h0000_1230, next_ip = 32'h0000_1232, ip1;
    logic        mem_req, mem_we, mem_ack;
    logic [3:0]  mem_be, delay = 4'h0;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, fetch_addr;
    logic        management_active, fetch_valid, resume_valid, shutdown;
    logic [31:0] instruction_pointer, mgmt_region_base;
    int          mismatches = 0, tests_run = 0, rv_cnt = 0, rv;

    always #2 clk_sys = ~clk_sys;
    // Count return pulses to spot a missed or extra resume
    // Sampled mid-cycle, away from the edge that launches the pulse
    always @(negedge clk_sys) if (resume_valid === 1'b1) rv_cnt++;

    smr_core u_dut (
        .clk_sys(clk_sys), .rst(rst), .ce(ce),
        .management_request_pin_n(pin_n), .lic_request(lic_request),
        .soft_init(soft_init), .resume_from_management(resume),
        .legacy_align(legacy_align), .io_trap(io_trap),
        .io_ip(io_ip), .next_ip(next_ip),
        .mem_req(mem_req), .mem_we(mem_we), .mem_be(mem_be),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .management_active(management_active),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
        .resume_valid(resume_valid),
        .instruction_pointer(instruction_pointer),
        .shutdown(shutdown), .mgmt_region_base(mgmt_region_base)
    );

    smr_mem_model u_mem (
        .clk_sys(clk_sys), .rst(rst), .mem_req(mem_req),
        .mem_we(mem_we), .mem_be(mem_be), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .delay(delay)
    );

    task complete_run;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One-cycle event: 0 controller, 1 resume, 2 pin, 3 soft init
    task pulse(input int k);
        @(negedge clk_sys);
        case (k)
            0: lic_request = 1'b1;
            1: resume = 1'b1;
            2: pin_n = 1'b0;
            default: soft_init = 1'b1;
        endcase
        @(negedge clk_sys);
        lic_request = 1'b0;
        resume = 1'b0;
        pin_n = 1'b1;
        soft_init = 1'b0;
    endtask

    // Wait for 0 fetch, 1 resume, 2 shutdown; bounded
    task wait_for(input int k);
        int n;
        n = 0;
        while (n < 200 && !((k == 0 && fetch_valid === 1'b1) ||
                            (k == 1 && resume_valid === 1'b1) ||
                            (k == 2 && shutdown === 1'b1))) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 200) begin
            mismatches++;
            $display("CHECK FAILED t=%0t wait ran out", $time);
            complete_run();
        end
    endtask

    // Entry with a stale FFH left in the restart field
    task entry(input logic [31:0] b, input int k);
        u_mem.mem[b + O_RST] = 32'h0000_00ff;
        pulse(k);
        wait_for(0);
        `CHK(fetch_addr, b + `SMR_ENTRY_OFS)
        `CHK(management_active, 1'b1)
        `CHK(u_mem.mem[b + O_REV][17:16], 2'b11)
        `CHK(u_mem.mem[b + O_RST][15:0], 16'h0000)
    endtask

    // Handler edits the save map, then resumes
    task leave(input logic [31:0] b, nb, rv_code, exp_ip);
        u_mem.mem[b + O_BASE] = nb;
        u_mem.mem[b + O_RST] = rv_code;
        pulse(1);
        wait_for(1);
        `CHK(instruction_pointer, exp_ip)
        `CHK(mgmt_region_base, nb)
        `CHK(management_active, 1'b0)
    endtask

    initial begin
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        `CHK(mgmt_region_base, `SMR_BASE_RESET)
        // Controller request, fast memory, restart on I/O trap
        io_trap = 1'b1;
        entry(`SMR_BASE_RESET, 0);
        leave(`SMR_BASE_RESET, B1, 32'h0000_00ff, io_ip);
        // Pin request, slow memory, soft init inside handler
        delay = 4'h3;
        entry(B1, 2);
        pulse(3);
        `CHK(mgmt_region_base, B1)
        leave(B1, B2, 32'h0000_0000, next_ip);
        // Undefined restart code behaves like 00H
        delay = 4'h1;
        io_trap = 1'b0;
        entry(B2, 0);
        // Clock enable low: a resume pulse is not taken
        ce = 1'b0;
        rv = rv_cnt;
        pulse(1);
        repeat (4) @(negedge clk_sys);
        `CHK(rv_cnt, rv)
        `CHK(management_active, 1'b1)
        `CHK(mgmt_region_base, B2)
        ce = 1'b1;
        leave(B2, B3, 32'h0000_005a, next_ip);
        // Second request while servicing an I/O trap
        io_trap = 1'b1;
        entry(B3, 0);
        ip1 = io_ip;
        rv = rv_cnt;
        pulse(0);
        u_mem.mem[B3 + O_BASE] = B4;
        u_mem.mem[B3 + O_RST] = 32'h0000_00ff;
        io_ip = 32'h0000_2000;
        next_ip = 32'h0000_2004;
        pulse(1);
        wait_for(0);
        `CHK(fetch_addr, B4 + `SMR_ENTRY_OFS)
        `CHK(rv_cnt, rv)
        `CHK(u_mem.mem[B4 + O_RST][15:0], 16'h0000)
        leave(B4, B5, 32'h0000_0000, ip1);
        // Legacy alignment: misaligned base shuts down
        legacy_align = 1'b1;
        entry(B5, 0);
        rv = rv_cnt;
        u_mem.mem[B5 + O_BASE] = 32'h0009_1000;
        pulse(1);
        wait_for(2);
        `CHK(mgmt_region_base, B5)
        `CHK(rv_cnt, rv)
        // Hardware reset restores the default base
        @(negedge clk_sys);
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        legacy_align = 1'b0;
        @(negedge clk_sys);
        `CHK(mgmt_region_base, `SMR_BASE_RESET)
        `CHK(shutdown, 1'b0)
        complete_run();
    end
endmodule
